/* logic/buzzer_consts.vh */
// constants for the buzzer tone, burst and envelope generator
`ifndef BUZZER_CONSTS_VH
`define BUZZER_CONSTS_VH

// register byte addresses
`define BZ_CTRL_ADDR 16'hFF54
`define BZ_TONE_ADDR 16'hFF55

// buzzer_control field positions
`define BZ_ABORT_BIT 6
`define BZ_TRIG_BIT  5
`define BZ_LEN_BIT   4
`define BZ_DECAY_BIT 3
`define BZ_ERST_BIT  2
`define BZ_EEN_BIT   1
`define BZ_TON_BIT   0

// buzzer_tone_select field positions
`define BZ_DUTY_LSB 4
`define BZ_FREQ_LSB 0

// reset values
`define BZ_CTRL_RESET 8'h00
`define BZ_TONE_RESET 8'h00

// clock and times in their own units
`define BZ_CLK_HZ          100000000
`define BZ_BASE_FREQ_HZ    4096
`define BZ_BURST_LONG_US   125000
`define BZ_BURST_SHORT_US  31250
`define BZ_DECAY_LONG_MS   1000
`define BZ_DECAY_SHORT_MS  500

// derived cycle counts
`define BZ_BASE_PERIOD_CYC (`BZ_CLK_HZ / `BZ_BASE_FREQ_HZ)
`define BZ_BURST_LONG_CYC  ((`BZ_CLK_HZ / 1000000) * `BZ_BURST_LONG_US)
`define BZ_BURST_SHORT_CYC ((`BZ_CLK_HZ / 1000000) * `BZ_BURST_SHORT_US)
`define BZ_DECAY_LONG_CYC  ((`BZ_CLK_HZ / 1000) * `BZ_DECAY_LONG_MS)
`define BZ_DECAY_SHORT_CYC ((`BZ_CLK_HZ / 1000) * `BZ_DECAY_SHORT_MS)

// envelope has this many attenuation steps, duty is in sixteenths
`define BZ_ENV_STEPS_LOG2 4
`define BZ_ENV_MAX        4'hF
`define BZ_DUTY_DEN_LOG2  4

`endif

/* logic/buzzer_tone_oneshot_envelope.v */
// buzzer tone generator with one-shot burst and decaying envelope
//
// What this block does
// - writing one to burst_abort stops a running burst at once, zero does nothing, it reads zero.
// - writing one to burst_trigger starts a timed burst and the bit reads one while it runs.
// - burst_length_select picks 125 msec when one and 31.25 msec when zero, cleared at reset.
// - decay_time_select picks a 1 sec envelope decay when one and 0.5 sec when zero.
// - writing one to envelope_restart returns the envelope to full level and the bit reads zero.
// - envelope_enable turns envelope attenuation on when one and off when zero.
// - envelope_enable is forced to zero while a burst is output so bursts never decay.
// - tone_enable drives the tone continuously when one; when zero the output is low unless a burst is running.
// - a three-bit freq_select field picks the tone frequency, code 000 giving 4096 Hz.

`timescale 1ns/10ps
`default_nettype none

`include "buzzer_consts.vh"

module buzzer_tone_oneshot_envelope #(
  parameter        ADDR_W          = 16,
  parameter [31:0] BASE_PERIOD_CYC = `BZ_BASE_PERIOD_CYC,
  parameter [31:0] BURST_LONG_CYC  = `BZ_BURST_LONG_CYC,
  parameter [31:0] BURST_SHORT_CYC = `BZ_BURST_SHORT_CYC,
  parameter [31:0] DECAY_LONG_CYC  = `BZ_DECAY_LONG_CYC,
  parameter [31:0] DECAY_SHORT_CYC = `BZ_DECAY_SHORT_CYC
) (
  input  wire              clk_in,
  input  wire              rst_in,
  input  wire [ADDR_W-1:0] addr_in,
  input  wire [7:0]        wdata_in,
  input  wire              wr_in,
  input  wire              rd_in,
  output reg  [7:0]        rdata_out,
  output reg               buzzer_out
);

  // tone period for a frequency code: the base period times (code + 1)
  function [31:0] tone_period;
    input [2:0] code;
    begin
      tone_period = BASE_PERIOD_CYC * ({29'h0, code} + 32'h1);
    end
  endfunction

  // high time: duty code 0 is half the period, each step takes one sixteenth off;
  // with envelope on, the high time shrinks by level sixteenths
  function [31:0] high_time;
    input [31:0] period;
    input [2:0]  duty;
    input [3:0]  level;
    input        atten;
    reg   [31:0] base;
    reg   [31:0] keep;
    begin
      base = (period * (32'h8 - {29'h0, duty})) >> `BZ_DUTY_DEN_LOG2;
      keep = atten ? (32'h10 - {28'h0, level}) : 32'h10;
      high_time = (base * keep) >> `BZ_ENV_STEPS_LOG2;
    end
  endfunction

  // register decode
  wire ctrl_sel;
  wire tone_sel;
  wire ctrl_wr;
  wire tone_wr;

  assign ctrl_sel = (addr_in == `BZ_CTRL_ADDR);
  assign tone_sel = (addr_in == `BZ_TONE_ADDR);
  assign ctrl_wr  = wr_in & ctrl_sel;
  assign tone_wr  = wr_in & tone_sel;

  wire abort_wr;
  wire trig_wr;
  wire restart_wr;

  assign abort_wr   = ctrl_wr & wdata_in[`BZ_ABORT_BIT];
  assign trig_wr    = ctrl_wr & wdata_in[`BZ_TRIG_BIT];
  assign restart_wr = ctrl_wr & wdata_in[`BZ_ERST_BIT];

  // reset images of both bytes, so each field takes its reset bit from one place
  wire [7:0] ctrl_reset;
  wire [7:0] tone_reset;

  assign ctrl_reset = `BZ_CTRL_RESET;
  assign tone_reset = `BZ_TONE_RESET;

  // control state
  reg        len_reg;
  reg        decay_reg;
  reg        env_en_reg;
  reg        tone_en_reg;
  reg        busy_reg;
  reg        busy_next;
  reg [2:0]  duty_reg;
  reg [2:0]  freq_reg;
  reg [31:0] burst_cnt_reg;
  reg [31:0] burst_cnt_next;

  // envelope state
  reg [3:0]  level_reg;
  reg [31:0] step_cnt_reg;
  wire [31:0] step_cyc;

  // tone state
  reg [31:0] phase_reg;
  wire [31:0] period_cyc;
  wire [31:0] high_cyc;
  wire        sound_on;

  // burst length in cycles for the length select bit carried by a trigger write
  function [31:0] burst_length;
    input sel;
    begin
      burst_length = sel ? BURST_LONG_CYC : BURST_SHORT_CYC;
    end
  endfunction

  // burst states; the state bit itself is the busy flag that software reads back
  localparam BURST_IDLE = 1'b0;
  localparam BURST_RUN  = 1'b1;

  // burst sequencing; abort wins over a trigger in the same write
  always @* begin
    busy_next      = busy_reg;
    burst_cnt_next = burst_cnt_reg;
    case (busy_reg)
      BURST_IDLE: begin
        if (abort_wr) begin
          busy_next      = BURST_IDLE;
          burst_cnt_next = 32'h0;
        end else if (trig_wr) begin
          busy_next      = BURST_RUN;
          burst_cnt_next = burst_length(wdata_in[`BZ_LEN_BIT]);
        end
      end
      BURST_RUN: begin
        if (abort_wr) begin
          busy_next      = BURST_IDLE;
          burst_cnt_next = 32'h0;
        end else if (trig_wr) begin
          burst_cnt_next = burst_length(wdata_in[`BZ_LEN_BIT]);
        end else if (burst_cnt_reg <= 32'h1) begin
          busy_next      = BURST_IDLE;
          burst_cnt_next = 32'h0;
        end else begin
          burst_cnt_next = burst_cnt_reg - 32'h1;
        end
      end
      default: begin
        busy_next      = BURST_IDLE;
        burst_cnt_next = 32'h0;
      end
    endcase
  end

  always @(posedge clk_in) begin
    if (rst_in) begin
      busy_reg      <= 1'b0;
      burst_cnt_reg <= 32'h0;
    end else begin
      busy_reg      <= busy_next;
      burst_cnt_reg <= burst_cnt_next;
    end
  end

  // read/write control bits
  always @(posedge clk_in) begin
    if (rst_in) begin
      len_reg     <= ctrl_reset[`BZ_LEN_BIT];
      decay_reg   <= ctrl_reset[`BZ_DECAY_BIT];
      tone_en_reg <= ctrl_reset[`BZ_TON_BIT];
    end else if (ctrl_wr) begin
      len_reg     <= wdata_in[`BZ_LEN_BIT];
      decay_reg   <= wdata_in[`BZ_DECAY_BIT];
      tone_en_reg <= wdata_in[`BZ_TON_BIT];
    end
  end

  // envelope enable; the burst override wins over any write
  always @(posedge clk_in) begin
    if (rst_in) begin
      env_en_reg <= ctrl_reset[`BZ_EEN_BIT];
    end else if (busy_next) begin
      env_en_reg <= 1'b0;
    end else if (ctrl_wr) begin
      env_en_reg <= wdata_in[`BZ_EEN_BIT];
    end
  end

  // tone select byte; bit 7 and bit 3 are not stored
  always @(posedge clk_in) begin
    if (rst_in) begin
      duty_reg <= tone_reset[`BZ_DUTY_LSB +: 3];
      freq_reg <= tone_reset[`BZ_FREQ_LSB +: 3];
    end else if (tone_wr) begin
      duty_reg <= wdata_in[`BZ_DUTY_LSB +: 3];
      freq_reg <= wdata_in[`BZ_FREQ_LSB +: 3];
    end
  end

  assign step_cyc = (decay_reg ? DECAY_LONG_CYC : DECAY_SHORT_CYC) >> `BZ_ENV_STEPS_LOG2;

  // envelope divider: a one-cycle step pulse every step_cyc cycles of enabled decay;
  // the count pauses with the envelope off so that re-enabling continues the decay
  reg step_tick_reg;

  always @(posedge clk_in) begin
    if (rst_in) begin
      step_cnt_reg  <= 32'h0;
      step_tick_reg <= 1'b0;
    end else if (restart_wr || !env_en_reg) begin
      step_cnt_reg  <= restart_wr ? 32'h0 : step_cnt_reg;
      step_tick_reg <= 1'b0;
    end else if (step_cnt_reg + 32'h1 >= step_cyc) begin
      step_cnt_reg  <= 32'h0;
      step_tick_reg <= 1'b1;
    end else begin
      step_cnt_reg  <= step_cnt_reg + 32'h1;
      step_tick_reg <= 1'b0;
    end
  end

  // envelope level climbs one step per pulse and then holds at the floor
  always @(posedge clk_in) begin
    if (rst_in) begin
      level_reg <= 4'h0;
    end else if (restart_wr) begin
      level_reg <= 4'h0;
    end else if (step_tick_reg && env_en_reg && (level_reg != `BZ_ENV_MAX)) begin
      level_reg <= level_reg + 4'h1;
    end
  end

  assign period_cyc = tone_period(freq_reg);
  assign high_cyc   = high_time(period_cyc, duty_reg, level_reg, env_en_reg);
  // tone on when enabled or bursting
  assign sound_on   = tone_en_reg | busy_reg;

  reg [31:0] phase_next;

  // phase restarts from zero whenever the tone starts, so the first cycle is whole
  always @* begin
    phase_next = phase_reg + 32'h1;
    if (!sound_on) begin
      phase_next = 32'h0;
    end else if (phase_reg + 32'h1 >= period_cyc) begin
      phase_next = 32'h0;
    end
  end

  always @(posedge clk_in) begin
    if (rst_in) begin
      phase_reg <= 32'h0;
    end else begin
      phase_reg <= phase_next;
    end
  end

  always @(posedge clk_in) begin
    if (rst_in) begin
      buzzer_out <= 1'b0;
    end else begin
      buzzer_out <= sound_on & (phase_reg < high_cyc);
    end
  end

  // read images; unused and write-only positions stay zero
  function [7:0] ctrl_image;
    input busy;
    input len;
    input decay;
    input env_en;
    input tone_en;
    begin
      ctrl_image                = 8'h00;
      ctrl_image[`BZ_TRIG_BIT]  = busy;
      ctrl_image[`BZ_LEN_BIT]   = len;
      ctrl_image[`BZ_DECAY_BIT] = decay;
      ctrl_image[`BZ_EEN_BIT]   = env_en;
      ctrl_image[`BZ_TON_BIT]   = tone_en;
    end
  endfunction

  function [7:0] tone_image;
    input [2:0] duty;
    input [2:0] freq;
    begin
      tone_image                    = 8'h00;
      tone_image[`BZ_DUTY_LSB +: 3] = duty;
      tone_image[`BZ_FREQ_LSB +: 3] = freq;
    end
  endfunction

  reg [7:0] rdata_next;

  // read data stands one cycle after the strobe and is zero otherwise
  always @* begin
    rdata_next = 8'h00;
    if (rd_in && ctrl_sel) begin
      rdata_next = ctrl_image(busy_reg, len_reg, decay_reg, env_en_reg, tone_en_reg);
    end else if (rd_in && tone_sel) begin
      rdata_next = tone_image(duty_reg, freq_reg);
    end
  end

  always @(posedge clk_in) begin
    if (rst_in) begin
      rdata_out <= 8'h00;
    end else begin
      rdata_out <= rdata_next;
    end
  end

endmodule

`default_nettype wire

/* verif/buzzer_checker_asserts.sv */
// checker for the buzzer register port and tone output
`timescale 1ns/10ps
`default_nettype none
module buzzer_checker #(parameter ADDR_W = 16) (
  input wire logic              clk_in,
  input wire logic              rst_in,
  input wire logic [ADDR_W-1:0] addr_in,
  input wire logic [7:0]        wdata_in,
  input wire logic              wr_in,
  input wire logic              rd_in,
  input wire logic [7:0]        rdata_out,
  input wire logic              buzzer_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  wire ctrl_sel = addr_in == 16'hFF54;
  wire tone_sel = addr_in == 16'hFF55;
  a_read_slot_only: assert property (rdata_out != 8'h00 |-> $past(rd_in))
    else $error("read data outside its slot");
  a_ctrl_unused_zero: assert property ($past(rd_in) && $past(ctrl_sel)
    |-> rdata_out[7:6] == 2'h0 && !rdata_out[2])
    else $error("control byte unused bits set");
  a_tone_unused_zero: assert property ($past(rd_in) && $past(tone_sel)
    |-> !rdata_out[7] && !rdata_out[3])
    else $error("tone byte unused bits set");
  a_unmapped_zero: assert property ($past(rd_in) && !$past(ctrl_sel) && !$past(tone_sel)
    |-> rdata_out == 8'h00)
    else $error("unmapped read not zero");
  a_tone_readback: assert property (wr_in && tone_sel ##1 rd_in && tone_sel
    |=> rdata_out == ($past(wdata_in, 2) & 8'h77))
    else $error("tone byte readback wrong");
  a_trigger_busy: assert property (wr_in && ctrl_sel && wdata_in[5] && !wdata_in[6]
    ##1 rd_in && ctrl_sel |=> rdata_out[5])
    else $error("trigger did not show busy");
  a_abort_idle: assert property (wr_in && ctrl_sel && wdata_in[6] ##1 rd_in && ctrl_sel
    |=> !rdata_out[5])
    else $error("abort left burst busy");
  a_burst_no_env: assert property ($past(rd_in) && $past(ctrl_sel) && rdata_out[5]
    |-> !rdata_out[1])
    else $error("envelope on during burst");
  a_abort_silent: assert property (wr_in && ctrl_sel && wdata_in == 8'h40
    |-> ##2 !buzzer_out)
    else $error("output active after abort");
endmodule
bind buzzer_tone_oneshot_envelope buzzer_checker #(.ADDR_W(ADDR_W)) chk_i (
  .clk_in(clk_in), .rst_in(rst_in), .addr_in(addr_in), .wdata_in(wdata_in),
  .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .buzzer_out(buzzer_out));
`default_nettype wire

/* verif/buzzer_listener.sv */
// buzzer transducer model tallying tone edges and high cycles
`timescale 1ns/10ps
`default_nettype none
module buzzer_listener (
  input  wire logic       clk_in,
  input  wire logic       buzzer_in,
  output var  logic [7:0] edges_out = 8'h00,
  output var  logic [7:0] high_out = 8'h00
);
  logic last_reg = 1'b0;
  // counts wrap; the bench only uses differences
  always @(posedge clk_in) begin
    last_reg <= buzzer_in;
    if (buzzer_in && !last_reg)
      edges_out <= edges_out + 8'h01;
    if (buzzer_in)
      high_out <= high_out + 8'h01;
  end
endmodule
`default_nettype wire

/* verif/testbench.sv */
// self-checking bench for the buzzer tone, burst and envelope block
`timescale 1ns/10ps
`default_nettype none
module testbench;
  logic        clk_in = 1'b0;
  logic        rst_in = 1'b1;
  logic [15:0] addr_in = 16'h0000;
  logic [7:0]  wdata_in = 8'h00;
  logic        wr_in = 1'b0;
  logic        rd_in = 1'b0;
  wire  [7:0]  rdata_out;
  wire         buzzer_out;
  wire  [7:0]  edges;
  wire  [7:0]  highs;
  int          fail_count = 0;
  int          checked = 0;
  logic [7:0]  v;
  logic [7:0]  ed;
  logic [7:0]  hi;
  // short counts keep the run brief: period 16, bursts 400/100, decays 320/160
  buzzer_tone_oneshot_envelope #(.BASE_PERIOD_CYC(32'd16), .BURST_LONG_CYC(32'd400),
    .BURST_SHORT_CYC(32'd100), .DECAY_LONG_CYC(32'd320), .DECAY_SHORT_CYC(32'd160)) dut (
    .clk_in(clk_in), .rst_in(rst_in), .addr_in(addr_in), .wdata_in(wdata_in),
    .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .buzzer_out(buzzer_out));
  buzzer_listener ear (.clk_in(clk_in), .buzzer_in(buzzer_out), .edges_out(edges),
    .high_out(highs));
  initial forever #5 clk_in = ~clk_in;
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge clk_in);
  endtask
  task automatic rd(input logic [15:0] a);
    wr_in <= 1'b0;
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge clk_in);
    rd_in <= 1'b0;
    #1;
    v = rdata_out;
    @(posedge clk_in);
  endtask
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    checked++;
    if (g !== e) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic hear(input int n);
    wr_in <= 1'b0;
    ed = edges;
    hi = highs;
    repeat (n) @(posedge clk_in);
    ed = edges - ed;
    hi = highs - hi;
  endtask
  task automatic t_regs;
    rd(16'hFF54);
    chk("control reset", 8'h00, v);
    rd(16'hFF55);
    chk("tone reset", 8'h00, v);
    wr(16'hFF55, 8'hFF);
    rd(16'hFF55);
    chk("tone rw", 8'h77, v);
    rd(16'hFF56);
    chk("unmapped", 8'h00, v);
    wr(16'hFF54, 8'hFF);
    rd(16'hFF54);
    chk("control rw", 8'h1B, v);
    wr(16'hFF54, 8'h40);
    $display("test regs done");
  endtask
  task automatic t_tone;
    logic [7:0] tb [3] = '{8'h00, 8'h40, 8'h01};
    logic [7:0] hx [3] = '{8'd80, 8'd40, 8'd80};
    logic [7:0] ex [3] = '{8'd10, 8'd10, 8'd5};
    for (int i = 0; i < 3; i++) begin
      wr(16'hFF55, tb[i]);
      wr(16'hFF54, 8'h01);
      hear(4);
      hear(160);
      chk("tone high", hx[i], hi);
      chk("tone edges", ex[i], ed);
      wr(16'hFF54, 8'h00);
    end
    hear(4);
    hear(160);
    chk("tone off", 8'h00, hi);
    $display("test tone done");
  endtask
  task automatic t_burst;
    wr(16'hFF54, 8'h20);
    hear(90);
    rd(16'hFF54);
    chk("short busy", 8'h20, v);
    repeat (10) @(posedge clk_in);
    rd(16'hFF54);
    chk("short end", 8'h00, v);
    wr(16'hFF54, 8'h32);
    rd(16'hFF54);
    chk("long busy", 8'h30, v);
    hear(64);
    chk("burst sound", 8'd32, hi);
    repeat (220) @(posedge clk_in);
    rd(16'hFF54);
    chk("long still", 8'h30, v);
    repeat (120) @(posedge clk_in);
    rd(16'hFF54);
    chk("long end", 8'h10, v);
    wr(16'hFF54, 8'h20);
    wr(16'hFF54, 8'h40);
    rd(16'hFF54);
    chk("abort", 8'h00, v);
    $display("test burst done");
  endtask
  task automatic t_env;
    wr(16'hFF55, 8'h00);
    wr(16'hFF54, 8'h03);
    hear(200);
    hear(32);
    chk("env faded", 8'h00, hi);
    wr(16'hFF54, 8'h07);
    hear(16);
    chk("env restart", 8'h01, {7'h00, hi != 8'h00});
    wr(16'hFF54, 8'h01);
    hear(4);
    hear(32);
    chk("env off", 8'd16, hi);
    wr(16'hFF54, 8'h0F);
    hear(200);
    hear(32);
    chk("slow decay", 8'h01, {7'h00, hi != 8'h00});
    $display("test env done");
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge clk_in);
    rst_in <= 1'b0;
    @(posedge clk_in);
    t_regs();
    t_tone();
    t_burst();
    t_env();
    conclude();
  end
endmodule
`default_nettype wire
